//--- common/led_power_pkg.sv
// Package: constants and types for colour select and power enables
package led_power_pkg;

    // Colour select codes
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_RED = 2'h1;
    localparam logic [1:0] SEL_GREEN = 2'h2;
    localparam logic [1:0] SEL_BLUE = 2'h3;

    // Clock and delay figures
    localparam int CLK_PERIOD_NS = 8;
    localparam int LIGHT_DELAY_MS = 100;
    localparam int MIRROR_HOLD_US = 500;
    localparam int LIGHT_DELAY_CYCLES =
        (LIGHT_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIRROR_HOLD_CYCLES =
        (MIRROR_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Reset value and PWM width
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam int PWM_WIDTH = 8;

    // Delay timer states
    typedef enum logic [2:0] {
        TMR_IDLE = 3'h1,
        TMR_COUNT = 3'h2,
        TMR_DONE = 3'h4
    } tmr_state_type;

endpackage : led_power_pkg

//--- common/delay_if.sv
// Interface: start/cancel and done between top and delay timer
`timescale 1ns/100ps
interface delay_if;
    logic run;
    logic done;
    modport ctl (output run, input done);
    modport tmr (input run, output done);
endinterface : delay_if

//--- rtl/delay_timer.sv
// Delay timer: done rises after run has held high for LENGTH + 1 cycles (one to start, LENGTH to count)
`timescale 1ns/100ps
module delay_timer
    import led_power_pkg::*;
#(
    parameter int LENGTH = 16
) (
    input wire logic sys_clk,
    input wire logic nrst,
    delay_if.tmr port
);

    logic [31:0] count;
    tmr_state_type state;

    ////////////////////////////////////////////////////////////////////////
    // Any drop of run cancels; a new rise restarts from zero
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state <= TMR_IDLE;
            count <= 32'h0;
        end else if (!port.run) begin
            state <= TMR_IDLE;
            count <= 32'h0;
        end else begin
            unique case (state)
                TMR_IDLE: begin
                    state <= TMR_COUNT;
                    count <= 32'h1;
                end
                TMR_COUNT: begin
                    if (count >= 32'(LENGTH)) begin
                        state <= TMR_DONE;
                    end else begin
                        count <= count + 32'h1;
                    end
                end
                TMR_DONE: begin
                    state <= TMR_DONE;
                end
                default: begin
                    state <= TMR_IDLE;
                end
            endcase
        end
    end

    // Gated by run so a drop clears done with no delay
    assign port.done = (state == TMR_DONE) && port.run;

endmodule : delay_timer

//--- rtl/led_power_ctrl.sv
// Colour select, blue PWM/output pin, light driver and mirror enables
// Behaviour
// - Blue pin is output only, never sampled
// - Without companion, blue pin carries PWM
// - With companion, pin is processor level
// - Select bus: 00 none,01 red,10 green,11 blue
// - Master enable after request high 100 ms
// - Master enable drops four edges after a low of two cycles or more
// - Mirror supply on while park high
// - Mirror supply held 500 us after park falls
`timescale 1ns/100ps
module led_power_ctrl
    import led_power_pkg::*;
#(
    parameter int LIGHT_CYCLES = LIGHT_DELAY_CYCLES,
    parameter int MIRROR_CYCLES = MIRROR_HOLD_CYCLES,
    parameter int QUAL_COUNT = 1
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic companion_present,
    input wire logic [PWM_WIDTH-1:0] blue_duty,
    input wire logic processor_level,
    input wire logic [1:0] sequencer_colour,
    input wire logic light_source_request,
    input wire logic [QUAL_COUNT-1:0] extra_qualifiers,
    input wire logic park,
    output logic blue_pwm_or_gpo,
    output logic colour_select_bit0,
    output logic colour_select_bit1,
    output logic light_driver_master_on,
    output logic mirror_supply_on
);

    // Three-stage pin synchronisers
    logic [2:0] req_sync;
    logic [2:0] park_sync;
    logic [QUAL_COUNT-1:0] qual_s1;
    logic [QUAL_COUNT-1:0] qual_s2;
    logic [QUAL_COUNT-1:0] qual_s3;
    // Filtered pin levels
    logic req_level;
    logic park_level;
    logic [QUAL_COUNT-1:0] qual_level;
    logic quals_ok;
    // Blue PWM, select and mirror hold state
    logic [PWM_WIDTH-1:0] pwm_phase;
    logic [1:0] colour;
    logic mirror_armed;
    // Timer handshakes
    delay_if light_dly ();
    delay_if mirror_dly ();

    ////////////////////////////////////////////////////////////////////////
    // Agreement filter: a level moves only when stages two and three match
    // A single odd sample between them never counts as a new level
    // Shared by the request, park and qualifier pins so all of them see the same latency
    function automatic logic agree_level(
        input logic stage2,
        input logic stage3,
        input logic held
    );
        logic result;
        result = held;
        if (stage2 == stage3) begin
            result = stage3;
        end
        return result;
    endfunction : agree_level

    // Same filter bit by bit, for the qualifier group
    function automatic logic [QUAL_COUNT-1:0] agree_bits(
        input logic [QUAL_COUNT-1:0] stage2,
        input logic [QUAL_COUNT-1:0] stage3,
        input logic [QUAL_COUNT-1:0] held
    );
        logic [QUAL_COUNT-1:0] result;
        result = held;
        for (int i = 0; i < QUAL_COUNT; i++) begin
            if (stage2[i] == stage3[i]) begin
                result[i] = stage3[i];
            end
        end
        return result;
    endfunction : agree_bits

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: stage 0 feeds only stage 1
    // Only stage 1 reads stage 0; a metastable first flop stays private
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            req_sync <= 3'h0;
            park_sync <= 3'h0;
            qual_s1 <= '0;
            qual_s2 <= '0;
            qual_s3 <= '0;
        end else begin
            req_sync <= {req_sync[1:0], light_source_request};
            park_sync <= {park_sync[1:0], park};
            qual_s1 <= extra_qualifiers;
            qual_s2 <= qual_s1;
            qual_s3 <= qual_s2;
        end
    end

    // Filtered levels change only when stages two and three agree
    // Costs one edge of latency; a lone glitch never reaches the timers
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            req_level <= 1'b0;
            park_level <= 1'b0;
            qual_level <= '0;
        end else begin
            req_level <= agree_level(req_sync[1], req_sync[2], req_level);
            park_level <= agree_level(park_sync[1], park_sync[2], park_level);
            qual_level <= agree_bits(qual_s2, qual_s3, qual_level);
        end
    end

    // Every qualifier must stand high for the driver
    assign quals_ok = &qual_level;

    ////////////////////////////////////////////////////////////////////////
    // Free-running phase; one PWM period is 2**PWM_WIDTH cycles
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pwm_phase <= '0;
        end else begin
            pwm_phase <= pwm_phase + 1'b1;
        end
    end

    // Blue pin: PWM alone or processor level
    // Pin has no input path at all
    // Full duty still leaves one low cycle per period, the price of a
    // plain compare that needs no extra phase bit
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            blue_pwm_or_gpo <= 1'b0;
        end else if (companion_present) begin
            blue_pwm_or_gpo <= processor_level;
        end else begin
            blue_pwm_or_gpo <= (pwm_phase < blue_duty);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Select bus registered from the sequencer code
    // Codes are one to one, so any 2-bit value is legal
    // Registered so both pins change on one edge together and an
    // external decoder never sees a mixed code between two colours
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            colour <= SEL_RESET;
        end else begin
            colour <= sequencer_colour;
        end
    end

    assign colour_select_bit0 = colour[0];
    assign colour_select_bit1 = colour[1];

    ////////////////////////////////////////////////////////////////////////
    // Master enable: timer runs while request and qualifiers hold
    // On the way up: four edges of pin filter, one to start the timer and
    // LIGHT_CYCLES to count, so the request stands a little longer than
    // the nominal delay. On the way down the same four edges pass, the
    // least the synchronisers allow; the drop adds none of its own.
    // The enable is a gate of the timer state and filtered levels, not a flop, to save that edge.
    assign light_dly.run = req_level && quals_ok;

    delay_timer #(
        .LENGTH(LIGHT_CYCLES)
    ) light_timer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .port(light_dly.tmr)
    );

    // Done is gated by run, so any low drops it at once
    assign light_driver_master_on = light_dly.done;

    ////////////////////////////////////////////////////////////////////////
    // Mirror supply: hold timer runs once park has fallen
    // A new park rise cancels the hold
    // Armed only by park high, so a power-up with park low never pulses
    // the regulators; park and done can never fall in one cycle
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            mirror_armed <= 1'b0;
        end else if (park_level) begin
            mirror_armed <= 1'b1;
        end else if (mirror_dly.done) begin
            mirror_armed <= 1'b0;
        end
    end

    assign mirror_dly.run = mirror_armed && !park_level;

    delay_timer #(
        .LENGTH(MIRROR_CYCLES)
    ) mirror_timer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .port(mirror_dly.tmr)
    );

    // High while parked and through the hold
    // Hold ends about MIRROR_CYCLES + 6 edges after the park pin falls,
    // never earlier than the nominal hold
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            mirror_supply_on <= 1'b0;
        end else begin
            mirror_supply_on <= park_level
                || (mirror_armed && !mirror_dly.done);
        end
    end

endmodule : led_power_ctrl

//--- tb/led_power_ctrl_assertions.sv
// Checker: timing and coding relations at the control block pins
`timescale 1ns/100ps
module led_power_ctrl_assertions
    import led_power_pkg::*;
#(
    parameter int LIGHT_CYCLES = 20,
    parameter int MIRROR_CYCLES = 10,
    parameter int QUAL_COUNT = 1
) (
    input logic sys_clk,
    input logic nrst,
    input logic companion_present,
    input logic [PWM_WIDTH-1:0] blue_duty,
    input logic processor_level,
    input logic [1:0] sequencer_colour,
    input logic light_source_request,
    input logic [QUAL_COUNT-1:0] extra_qualifiers,
    input logic park,
    input logic blue_pwm_or_gpo,
    input logic colour_select_bit0,
    input logic colour_select_bit1,
    input logic light_driver_master_on,
    input logic mirror_supply_on
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic [7:0] req_run;
    logic [7:0] low_run;
    logic req_ok;
    assign req_ok = light_source_request && (&extra_qualifiers);
    // Run lengths; saturate so a long level never wraps
    always_ff @(posedge sys_clk) begin
        if (!nrst || !req_ok) req_run <= 8'h00;
        else if (req_run != 8'hFF) req_run <= req_run + 8'h01;
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst || park) low_run <= 8'h00;
        else if (low_run != 8'hFF) low_run <= low_run + 8'h01;
    end
    //////////////////////////////////////////////////////////////////////
    AST_SEL: assert property ($past(nrst) |->
        {colour_select_bit1, colour_select_bit0} == $past(sequencer_colour))
        else $error("colour select does not follow sequencer");
    AST_GPO: assert property ($past(nrst) && $past(companion_present) |->
        blue_pwm_or_gpo == $past(processor_level))
        else $error("blue pin does not follow processor level");
    AST_PWM: assert property ((!companion_present && blue_duty == 8'hFF)[*3]
        |-> ##[0:1] blue_pwm_or_gpo) else $error("full duty pwm stays low");
    AST_WAIT: assert property ($rose(light_driver_master_on) |->
        req_run >= LIGHT_CYCLES) else $error("driver enabled too early");
    AST_LATE: assert property (req_run == LIGHT_CYCLES + 9 |->
        light_driver_master_on) else $error("driver enable missing");
    AST_OFF: assert property ((!req_ok)[*6] |-> !light_driver_master_on)
        else $error("driver enable not dropped");
    AST_PARK: assert property (park[*6] |-> mirror_supply_on)
        else $error("mirror supply off while parked");
    AST_HOLD: assert property ($fell(mirror_supply_on) |->
        low_run >= MIRROR_CYCLES) else $error("mirror supply hold too short");
    AST_RISE: assert property ($rose(mirror_supply_on) |->
        $past(park, 5)) else $error("mirror supply on without park");
endmodule : led_power_ctrl_assertions
bind led_power_ctrl led_power_ctrl_assertions #(.LIGHT_CYCLES(LIGHT_CYCLES),
    .MIRROR_CYCLES(MIRROR_CYCLES), .QUAL_COUNT(QUAL_COUNT)) u_chk (.sys_clk,
    .nrst, .companion_present, .blue_duty, .processor_level,
    .sequencer_colour, .light_source_request, .extra_qualifiers, .park,
    .blue_pwm_or_gpo, .colour_select_bit0, .colour_select_bit1,
    .light_driver_master_on, .mirror_supply_on);

//--- tb/colour_decoder.sv
// Model: external decode of the colour select pins into lamp enables
`timescale 1ns/100ps
module colour_decoder (
    input logic [1:0] colour_select_bus,
    output logic [2:0] lamp_on
);
    // Red, green, blue enables; none lit for the idle code
    assign lamp_on = (colour_select_bus == 2'h0) ? 3'h0 :
        3'(3'h1 << (2'h3 - colour_select_bus));
endmodule : colour_decoder

//--- tb/tb.sv
// Testbench: colour select, blue pin and power enable scenarios
`timescale 1ns/100ps
module tb;
    import led_power_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic companion_present = 1'b0;
    logic [PWM_WIDTH-1:0] blue_duty = 8'h00;
    logic processor_level = 1'b0;
    logic [1:0] sequencer_colour = 2'h0;
    logic light_source_request = 1'b0;
    logic [0:0] extra_qualifiers = 1'h1;
    logic park = 1'b0;
    logic blue_pwm_or_gpo, colour_select_bit0, colour_select_bit1;
    logic light_driver_master_on, mirror_supply_on;
    logic [2:0] lamp_on;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    // Short delays: 20 cycles for the driver, 10 for the mirror hold
    led_power_ctrl #(.LIGHT_CYCLES(20), .MIRROR_CYCLES(10)) u_led_power_ctrl
        (.sys_clk, .nrst, .companion_present, .blue_duty, .processor_level,
        .sequencer_colour, .light_source_request, .extra_qualifiers, .park,
        .blue_pwm_or_gpo, .colour_select_bit0, .colour_select_bit1,
        .light_driver_master_on, .mirror_supply_on);
    colour_decoder u_colour_decoder (.colour_select_bus({colour_select_bit1,
        colour_select_bit0}), .lamp_on);
    always #4 sys_clk = ~sys_clk;
    //////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : step
    // Sample just after the edge so its updates have landed
    task automatic chk(input logic [7:0] exp, input logic [7:0] act);
        #1;
        num_checks++;
        if (act !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t exp=%h act=%h", $time, exp, act);
        end
    endtask : chk
    task automatic test_done();
        if (failures == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    task automatic sc_reset();
        step(3);
        chk(8'h00, 8'(mirror_supply_on));
        chk(8'h00, 8'(light_driver_master_on));
        chk(8'h00, 8'(blue_pwm_or_gpo));
        chk(8'h00, 8'(lamp_on));
    endtask : sc_reset
    task automatic sc_select();
        logic [2:0] lamp [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
        for (int i = 0; i < 4; i++) begin
            step(1);
            sequencer_colour <= 2'(i);
            step(2);
            chk(8'(lamp[i]), 8'(lamp_on));
        end
    endtask : sc_select
    task automatic sc_blue();
        int hi = 0;
        step(1);
        companion_present <= 1'b1;
        processor_level <= 1'b1;
        step(3);
        chk(8'h01, 8'(blue_pwm_or_gpo));
        step(1);
        companion_present <= 1'b0;
        blue_duty <= 8'hFF;
        step(8);
        blue_duty <= 8'h80;
        step(4);
        // Half duty: 128 high cycles in any 256
        repeat (256) begin
            step(1);
            #1 hi += blue_pwm_or_gpo;
        end
        chk(8'h80, 8'(hi));
    endtask : sc_blue
    task automatic sc_light();
        step(1);
        light_source_request <= 1'b1;
        step(10);
        light_source_request <= 1'b0;
        step(40);
        chk(8'h00, 8'(light_driver_master_on));
        step(1);
        light_source_request <= 1'b1;
        step(20);
        chk(8'h00, 8'(light_driver_master_on));
        step(15);
        chk(8'h01, 8'(light_driver_master_on));
        step(1);
        extra_qualifiers <= 1'h0;
        step(6);
        chk(8'h00, 8'(light_driver_master_on));
    endtask : sc_light
    task automatic sc_mirror();
        step(1);
        park <= 1'b1;
        step(6);
        chk(8'h01, 8'(mirror_supply_on));
        step(1);
        park <= 1'b0;
        step(10);
        chk(8'h01, 8'(mirror_supply_on));
        step(15);
        chk(8'h00, 8'(mirror_supply_on));
    endtask : sc_mirror
    //////////////////////////////////////////////////////////////////////
    initial begin
        step(5);
        nrst <= 1'b1;
        sc_reset();
        sc_select();
        sc_blue();
        sc_light();
        sc_mirror();
        test_done();
    end
    // Hang guard well above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            test_done();
        end
    end
endmodule : tb
